// ---- verilog/itc_channel.sv ----
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/10ps
module itc_channel #(
  parameter int CHAN = 1,
  parameter int PSC_W = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire itc_pkg::itc_apb_req_t apbReq,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timerInputPin,
  output logic timerOutputPin,
  output logic timerOutputPinOe_n,
  output logic channelInterrupt,
  output logic inputEdge
);
  // each prescaler field needs four bits to reach every divide setting
  if (CHAN < 0 || CHAN > 7 || PSC_W < 4 || PSC_W > 8) begin : gBadParam
    $error("itc_channel: bad parameter");
  end

  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  logic unitEnable_ff;
  logic [4*PSC_W-1:0] clockSelectReg_ff;
  logic [15:0] channelModeReg_ff;
  logic [15:0] channelDataReg_ff;
  logic [15:0] channelCounter_ff;
  logic channelRunning_ff;
  logic startPend_ff;
  logic outValue_ff;
  logic outEnable_ff;
  logic outMode_ff;
  logic outLevel_ff;
  logic portOut_ff;
  logic portLatch_ff;
  logic [15:0] nxtMode;
  logic wrAcc;
  logic rdAcc;
  logic wrEn;
  logic [31:0] rdMux;
  logic badAddr;

  assign wrAcc = apbReq.psel && apbReq.penable && apbReq.pwrite;
  assign rdAcc = apbReq.psel && apbReq.penable && !apbReq.pwrite;
  // unit disabled: only the enable register itself is writable
  assign wrEn = wrAcc && unitEnable_ff;

  // address decode; unmapped reads zero with an error answer
  always_comb begin
    rdMux = itc_pkg::ZERO32;
    badAddr = 1'b0;
    if (apbReq.paddr == itc_pkg::ADDR_UNIT) begin
      rdMux[0] = unitEnable_ff;
    end else if (apbReq.paddr == itc_pkg::ADDR_PSC) begin
      rdMux[4*PSC_W-1:0] = clockSelectReg_ff;
    end else if (apbReq.paddr == itc_pkg::ADDR_MODE) begin
      rdMux[15:0] = channelModeReg_ff;
    end else if (apbReq.paddr == itc_pkg::ADDR_DATA) begin
      rdMux[15:0] = channelDataReg_ff;
    end else if (apbReq.paddr == itc_pkg::ADDR_CTRL) begin
      rdMux = itc_pkg::ZERO32;  // trigger bits always read 0
    end else if (apbReq.paddr == itc_pkg::ADDR_OUT) begin
      rdMux[3:0] = {outLevel_ff, outMode_ff, outEnable_ff, outValue_ff};
    end else if (apbReq.paddr == itc_pkg::ADDR_PORT) begin
      rdMux[1:0] = {portLatch_ff, portOut_ff};
    end else if (apbReq.paddr == itc_pkg::ADDR_CNT) begin
      rdMux[15:0] = channelCounter_ff;
    end else if (apbReq.paddr == itc_pkg::ADDR_STAT) begin
      rdMux[0] = channelRunning_ff;
    end else begin
      badAddr = 1'b1;
    end
  end

  // zero-wait slave: pready and read data registered in the setup cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= itc_pkg::ZERO32;
      pslverr <= 1'b0;
    end else begin
      pready <= apbReq.psel && !apbReq.penable;
      prdata <= (apbReq.psel && !apbReq.penable && !apbReq.pwrite) ?
                rdMux : itc_pkg::ZERO32;
      pslverr <= apbReq.psel && !apbReq.penable && badAddr;
    end
  end

  // unit enable; clearing it returns every bus register to reset values, while the prescaler counter and input filter keep their state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unitEnable_ff <= 1'b0;
    end else if (wrAcc && pready && apbReq.paddr == itc_pkg::ADDR_UNIT) begin
      unitEnable_ff <= apbReq.pwdata[0];
    end
  end

  // mode bit 11 held at zero on channels without master or split
  always_comb begin
    nxtMode = apbReq.pwdata[15:0];
    if (CHAN == 0 || CHAN == 5 || CHAN == 7) begin
      nxtMode[itc_pkg::MODE_MSTR] = 1'b0;
    end
    if (CHAN != 1 && CHAN != 3) begin
      nxtMode[itc_pkg::MODE_CKS_LO] = 1'b0;  // clocks 2,3 not here
    end
  end

  // configuration registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clockSelectReg_ff <= '0;
      channelModeReg_ff <= itc_pkg::ZERO16;
      channelDataReg_ff <= itc_pkg::ZERO16;
      outEnable_ff <= 1'b0;
      outMode_ff <= 1'b0;
      outLevel_ff <= 1'b0;
      portOut_ff <= 1'b0;
      portLatch_ff <= 1'b0;
    end else if (!unitEnable_ff) begin
      clockSelectReg_ff <= '0;
      channelModeReg_ff <= itc_pkg::ZERO16;
      channelDataReg_ff <= itc_pkg::ZERO16;
      outEnable_ff <= 1'b0;
      outMode_ff <= 1'b0;
      outLevel_ff <= 1'b0;
      portOut_ff <= 1'b0;
      portLatch_ff <= 1'b0;
    end else if (wrEn && pready) begin
      if (apbReq.paddr == itc_pkg::ADDR_PSC) begin
        clockSelectReg_ff <= apbReq.pwdata[4*PSC_W-1:0];
      end else if (apbReq.paddr == itc_pkg::ADDR_MODE) begin
        channelModeReg_ff <= nxtMode;
      end else if (apbReq.paddr == itc_pkg::ADDR_DATA) begin
        channelDataReg_ff <= apbReq.pwdata[15:0];  // any time
      end else if (apbReq.paddr == itc_pkg::ADDR_OUT) begin
        outEnable_ff <= apbReq.pwdata[itc_pkg::OUT_EN];
        outMode_ff <= apbReq.pwdata[itc_pkg::OUT_MODE];
        outLevel_ff <= apbReq.pwdata[itc_pkg::OUT_LVL];
      end else if (apbReq.paddr == itc_pkg::ADDR_PORT) begin
        portOut_ff <= apbReq.pwdata[itc_pkg::PORT_OE];
        portLatch_ff <= apbReq.pwdata[itc_pkg::PORT_LAT];
      end
    end
  end

  // ---------------------------------------------------------------
  // prescaler and operation clock enable
  // ---------------------------------------------------------------
  // four power-of-two prescalers off one free counter; a clock tick is
  // a one-cycle enable, so no derived clock nets are created
  logic [15:0] preCnt_ff;
  logic [3:0] preTick;
  logic opTick;
  logic [1:0] cksSel;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      preCnt_ff <= itc_pkg::ZERO16;
    end else if (unitEnable_ff) begin
      preCnt_ff <= preCnt_ff + 16'h0001;  // stopped while unit off
    end
  end

  // tick k when the low sel bits of the counter are all ones
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      logic [3:0] sel;
      logic [15:0] mask;
      sel = clockSelectReg_ff[k*PSC_W +: 4];
      mask = (16'h0001 << sel) - 16'h0001;
      preTick[k] = unitEnable_ff && ((preCnt_ff & mask) == mask);
    end
  end

  // select field: 00->0, 10->1, 01->2, 11->3
  assign cksSel = channelModeReg_ff[itc_pkg::MODE_CKS_HI:
                                    itc_pkg::MODE_CKS_LO];
  always_comb begin
    if (cksSel == 2'b00) begin
      opTick = preTick[0];
    end else if (cksSel == 2'b10) begin
      opTick = preTick[1];
    end else if (cksSel == 2'b01) begin
      opTick = preTick[2];
    end else begin
      opTick = preTick[3];
    end
  end

  // ---------------------------------------------------------------
  // input conditioning
  // ---------------------------------------------------------------
  logic inUsed;
  logic filtTick;
  logic sync1_ff;
  logic sync2_ff;
  logic samp_ff;
  logic filtOut_ff;
  logic filtPrev_ff;

  assign inUsed = channelModeReg_ff[itc_pkg::MODE_CCS] ||
                  channelModeReg_ff[itc_pkg::MODE_STS1] ||
                  channelModeReg_ff[itc_pkg::MODE_STS0];
  assign filtTick = opTick && inUsed;  // unused input: clock gated

  // two-stage synchroniser on the raw pin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= timerInputPin;
      sync2_ff <= sync1_ff;
    end
  end

  // filter: on operation clock ticks; with filter off just resample
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      samp_ff <= 1'b0;
      filtOut_ff <= 1'b0;
    end else if (filtTick) begin
      samp_ff <= sync2_ff;
      if (!channelModeReg_ff[itc_pkg::MODE_NFEN]) begin
        filtOut_ff <= sync2_ff;
      end else if (samp_ff == sync2_ff) begin
        filtOut_ff <= sync2_ff;  // held FILT_HOLD samples
      end
    end
  end

  // edge detector after the filter, result to the timer control
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      filtPrev_ff <= 1'b0;
      inputEdge <= 1'b0;
    end else begin
      filtPrev_ff <= filtOut_ff;
      inputEdge <= filtOut_ff ^ filtPrev_ff;
    end
  end

  // ---------------------------------------------------------------
  // interval counter
  // ---------------------------------------------------------------
  logic startWr;
  logic stopWr;
  logic fire;

  assign startWr = wrEn && pready && apbReq.paddr == itc_pkg::ADDR_CTRL &&
                   apbReq.pwdata[itc_pkg::CTRL_START];
  assign stopWr = wrEn && pready && apbReq.paddr == itc_pkg::ADDR_CTRL &&
                  apbReq.pwdata[itc_pkg::CTRL_STOP];

  // run state; stop wins over a start in the same write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      channelRunning_ff <= 1'b0;  // stopped until started
      startPend_ff <= 1'b0;
    end else if (!unitEnable_ff || stopWr) begin
      channelRunning_ff <= 1'b0;
      startPend_ff <= 1'b0;
    end else if (startWr) begin
      channelRunning_ff <= 1'b1;
      startPend_ff <= 1'b1;
    end else if (opTick) begin
      startPend_ff <= 1'b0;
    end
  end

  // count down; load on first tick after start, reload after zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      channelCounter_ff <= itc_pkg::ZERO16;
    end else if (!unitEnable_ff) begin
      channelCounter_ff <= itc_pkg::ZERO16;
    end else if (channelRunning_ff && opTick && !stopWr) begin
      if (startPend_ff) begin
        channelCounter_ff <= channelDataReg_ff;
      end else if (channelCounter_ff == itc_pkg::ZERO16) begin
        channelCounter_ff <= channelDataReg_ff;
      end else begin
        channelCounter_ff <= channelCounter_ff - 16'h0001;
      end
    end
  end

  assign fire = channelRunning_ff && opTick && !stopWr && unitEnable_ff &&
                (startPend_ff ? channelModeReg_ff[itc_pkg::MODE_SINT] :
                 channelCounter_ff == itc_pkg::ZERO16);

  // one-cycle interrupt pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      channelInterrupt <= 1'b0;
    end else begin
      channelInterrupt <= fire;
    end
  end

  // output bit: software writes only while enable is 0, toggle when 1
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      outValue_ff <= 1'b0;
    end else if (!unitEnable_ff) begin
      outValue_ff <= 1'b0;
    end else if (outEnable_ff) begin
      if (fire) begin
        outValue_ff <= !outValue_ff;
      end
    end else if (wrEn && pready && apbReq.paddr == itc_pkg::ADDR_OUT) begin
      outValue_ff <= apbReq.pwdata[itc_pkg::OUT_VAL];
    end
  end

  // pin: hi-z until port output; latch 0 passes the output bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timerOutputPin <= 1'b0;
      timerOutputPinOe_n <= 1'b1;
    end else begin
      timerOutputPin <= outValue_ff & !portLatch_ff;
      timerOutputPinOe_n <= !portOut_ff;
    end
  end
endmodule

// ---- verilog/itc_pkg.sv ----
// How it works
// - input pin passes noise filter then edge detector before timer control.
// - filter off: input is only synchronised to the operation clock.
// - filter on: new level accepted after two equal operation clock samples.
// - input unused: filter gets no operation clock.
// - interrupt every data value plus one count clocks.
// - output toggles on each interrupt, 50% duty square wave.
// - counter counts down once per count clock.
// - start trigger loads counter from data register on next count clock.
// - start load interrupts and toggles only when start interrupt bit is 1.
// - at zero, next count clock interrupts, toggles and reloads.
// - data register writable anytime, used at next reload.
// - operation clock select 00,10 pick clocks 0,1; 01,11 clocks 2,3.
// - output enable 0 stops counter driven output changes.
// - unit enable clear stops clocks and ignores other writes.
// - clock select register sets the four prescaled clock rates.
// - pin high impedance until port output enabled; then drives output bit while port latch is 0, and 0 while it is 1.
// - configured channel stays stopped until started.
// - mode bit 11 is master, split or fixed zero by channel number.
// - stop trigger halts count, holds counter and output, self clears.
package itc_pkg;
  localparam logic [7:0] ADDR_UNIT = 8'h00;  // unit enable, bit 0
  localparam logic [7:0] ADDR_PSC = 8'h04;   // clock select, four nibbles
  localparam logic [7:0] ADDR_MODE = 8'h08;  // channel mode
  localparam logic [7:0] ADDR_DATA = 8'h0C;  // period value
  localparam logic [7:0] ADDR_CTRL = 8'h10;  // start/stop triggers, write
  localparam logic [7:0] ADDR_OUT = 8'h14;   // output value/enable/mode/level
  localparam logic [7:0] ADDR_PORT = 8'h18;  // port output mode and latch
  localparam logic [7:0] ADDR_CNT = 8'h1C;   // counter, read only
  localparam logic [7:0] ADDR_STAT = 8'h20;  // running flag, read only
  // mode register field positions
  localparam int MODE_CKS_HI = 15;
  localparam int MODE_CKS_LO = 14;
  localparam int MODE_CCS = 12;
  localparam int MODE_MSTR = 11;
  localparam int MODE_STS1 = 9;
  localparam int MODE_STS0 = 8;
  localparam int MODE_NFEN = 7;  // input filter enable
  localparam int MODE_SINT = 0;  // start interrupt bit
  // control register
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP = 1;
  // output register
  localparam int OUT_VAL = 0;
  localparam int OUT_EN = 1;
  localparam int OUT_MODE = 2;
  localparam int OUT_LVL = 3;
  // port register
  localparam int PORT_OE = 0;
  localparam int PORT_LAT = 1;
  localparam int FILT_HOLD = 2;  // equal samples needed
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [3:0] PSC_RST = 4'h0;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } itc_apb_req_t;
endpackage

// ---- testbench/itc_channel_props.sv ----
`timescale 1ns/10ps
module itc_channel_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire itc_pkg::itc_apb_req_t apbReq,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic timerOutputPinOe_n,
  input wire logic channelInterrupt,
  input wire logic inputEdge
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // -------------------------------------------------
  // bus phases
  // -------------------------------------------------
  sequence setupPh;
    apbReq.psel && !apbReq.penable;
  endsequence
  sequence accessPh;
    apbReq.psel && apbReq.penable && pready;
  endsequence
  setup_answer_a: assert property (setupPh |=> accessPh)
    else $error("no answer after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  err_zero_a: assert property (pslverr |-> prdata == 32'h0)
    else $error("error read not zero");
  idle_zero_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  unmapped_err_a: assert property (
    setupPh ##0 apbReq.paddr > 8'h20 |=> pslverr)
    else $error("unmapped not refused");
  mapped_ok_a: assert property (setupPh ##0
    (apbReq.paddr <= 8'h20 && apbReq.paddr[1:0] == 2'h0) |=> !pslverr)
    else $error("mapped refused");
  reset_quiet_a: assert property ($rose(rst_n) |->
    timerOutputPinOe_n && !channelInterrupt && !inputEdge && !pready)
    else $error("outputs active after reset");
endmodule

// ---- testbench/itc_pin_model.sv ----
`timescale 1ns/10ps
module itc_pin_model (
  input wire logic clk,
  input wire logic drvLevel,
  input wire logic outPin,
  input wire logic outOe_n,
  output logic timerInputPin,
  output logic pinLevel
);
  logic last = 1'h0;
  initial timerInputPin = 1'h0;
  // the source changes just after an edge, like a synchronous driver
  always @(posedge clk) begin
    timerInputPin <= drvLevel;
  end
  // undriven pin has no pull, so show a wandering level, not the old one
  always @(posedge clk) begin
    last <= outOe_n ? ~last : outPin;
  end
  assign pinLevel = outOe_n ? ~last : outPin;
endmodule

// ---- testbench/testbench.sv ----
`timescale 1ns/10ps
module testbench;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  itc_pkg::itc_apb_req_t req = '0;
  logic [31:0] prdata, rd, seed = 32'h1C;
  logic pready, pslverr, inPin, outPin, outOe_n, irq, edgeP;
  logic er, lvl, pinLevel;
  logic drvLevel = 1'h0;
  int err_count = 0, n_checks = 0, cyc = 0, edges = 0;
  int t0, t1, t2, d, d2, eb;
  itc_channel #(.CHAN(1)) itc_channel_i (.clk(clk), .rst_n(rst_n),
    .apbReq(req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timerInputPin(inPin), .timerOutputPin(outPin),
    .timerOutputPinOe_n(outOe_n), .channelInterrupt(irq),
    .inputEdge(edgeP));
  itc_pin_model itc_pin_model_i (.clk(clk), .drvLevel(drvLevel),
    .outPin(outPin), .outOe_n(outOe_n), .timerInputPin(inPin),
    .pinLevel(pinLevel));
  always #5 clk = ~clk;
  // cycle stamps and a ceiling well above the planned run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (edgeP === 1'h1) edges <= edges + 1;
    if (cyc == 20000) begin
      err_count++;
      results();
    end
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic int gap(input int v);
    return v + 1;
  endfunction
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task results();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one bus transfer; the request stands until ready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    req.psel <= 1'h1;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= wd;
    @(posedge clk);
    req.penable <= 1'h1;
    // only the bench ceiling ends a missing answer
    do begin
      @(posedge clk);
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    req.psel <= 1'h0;
    req.penable <= 1'h0;
    @(posedge clk);
  endtask
  // stamp the next interrupt, then let the output settle
  task waitIrq(output int t);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (irq !== 1'h1 && n < 300);
    t = cyc;
    check(irq, 32'h1);
    repeat (2) @(posedge clk);
  endtask
  task pulseIn(input int hold, input int expEdges);
    eb = edges;
    drvLevel <= ~drvLevel;
    repeat (hold) @(posedge clk);
    drvLevel <= ~drvLevel;
    repeat (10) @(posedge clk);
  endtask
  // -------------------------------------------------
  // main sequence
  // -------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    check(outOe_n, 32'h1);
    apb(1'h1, itc_pkg::ADDR_MODE, 32'h1);
    apb(1'h0, itc_pkg::ADDR_MODE, 32'h0);
    check(rd, 32'h0);
    apb(1'h1, itc_pkg::ADDR_UNIT, 32'h1);
    apb(1'h1, itc_pkg::ADDR_PSC, 32'h0);
    apb(1'h0, itc_pkg::ADDR_STAT, 32'h0);
    check(rd, 32'h0);
    apb(1'h0, 8'h40, 32'h0);
    check(er, 32'h1);
    // long enough that the mid-period data write lands before the reload
    d = 12 + xs() % 5;
    d2 = 12 + xs() % 5;
    // clock 0, start interrupt on, output enabled, level 0
    apb(1'h1, itc_pkg::ADDR_MODE, 32'h1);
    apb(1'h1, itc_pkg::ADDR_DATA, d);
    apb(1'h1, itc_pkg::ADDR_OUT, 32'h2);
    apb(1'h1, itc_pkg::ADDR_PORT, 32'h1);
    @(posedge clk);
    check(outOe_n, 32'h0);
    apb(1'h1, itc_pkg::ADDR_CTRL, 32'h1);
    t0 = cyc;
    waitIrq(t1);
    check(t1 - t0 <= 3, 32'h1);
    lvl = pinLevel;
    waitIrq(t2);
    check(t2 - t1, gap(d));
    check(pinLevel, !lvl);
    apb(1'h0, itc_pkg::ADDR_CNT, 32'h0);
    check(rd < d, 32'h1);
    apb(1'h1, itc_pkg::ADDR_DATA, d2);
    waitIrq(t1);
    check(t1 - t2, gap(d));
    waitIrq(t2);
    check(t2 - t1, gap(d2));
    check(pinLevel, !lvl);
    lvl = pinLevel;
    apb(1'h1, itc_pkg::ADDR_OUT, {31'h0, lvl});
    waitIrq(t1);
    check(pinLevel, lvl);
    waitIrq(t1);
    check(pinLevel, lvl);
    apb(1'h1, itc_pkg::ADDR_CTRL, 32'h2);
    apb(1'h0, itc_pkg::ADDR_CNT, 32'h0);
    t0 = rd;
    repeat (20) @(posedge clk);
    apb(1'h0, itc_pkg::ADDR_CNT, 32'h0);
    check(rd, t0);
    apb(1'h0, itc_pkg::ADDR_CTRL, 32'h0);
    check(rd, 32'h0);
    apb(1'h1, itc_pkg::ADDR_MODE, 32'h0);
    apb(1'h1, itc_pkg::ADDR_CTRL, 32'h1);
    t0 = cyc;
    waitIrq(t1);
    check(t1 - t0 >= d2, 32'h1);
    // prescaled clock 1 at divide by two, selected by field value 10
    apb(1'h1, itc_pkg::ADDR_PSC, 32'h10);
    apb(1'h1, itc_pkg::ADDR_MODE, 32'h8000);
    waitIrq(t1);
    waitIrq(t2);
    check(t2 - t1, 2 * gap(d2));
    apb(1'h1, itc_pkg::ADDR_CTRL, 32'h2);
    // input path: unused, then filter off, then filter on
    pulseIn(4, 0);
    check(edges - eb, 32'h0);
    apb(1'h1, itc_pkg::ADDR_MODE, 32'h1000);
    repeat (2) @(posedge clk);
    pulseIn(1, 2);
    check(edges - eb, 32'h2);
    apb(1'h1, itc_pkg::ADDR_MODE, 32'h1080);
    repeat (4) @(posedge clk);
    pulseIn(1, 0);
    check(edges - eb, 32'h0);
    pulseIn(4 + xs() % 4, 2);
    check(edges - eb, 32'h2);
    results();
  end
endmodule
bind itc_channel itc_channel_props itc_channel_props_i (.clk(clk),
  .rst_n(rst_n), .apbReq(apbReq), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .timerOutputPinOe_n(timerOutputPinOe_n),
  .channelInterrupt(channelInterrupt), .inputEdge(inputEdge));
